/* logic/prdc_pkg.sv */
// Purpose: Shared constants for the pixel rectangle draw converter
// Assumes: Elements are 16 bit; float components are signed Q4.12
// Notes:   Format, type and clamp codes are driven by the command logic
package prdc_pkg;
  localparam int          FRAG_W        = 280;
  localparam logic [15:0] FP_ONE        = 16'h1000;
  localparam logic [15:0] INT_ONE       = 16'h0001;
  localparam logic [15:0] ELEM_ZERO     = 16'h0000;
  localparam logic [15:0] WINZ_MAX      = 16'hffff;
  localparam logic [7:0]  BYTE_FULL     = 8'hff;
  localparam logic [2:0]  LAST_BIT      = 3'h7;
  localparam int          FP_INT_LSB    = 12;

  localparam logic [3:0]  F_INDEX       = 4'h0;
  localparam logic [3:0]  F_STENCIL     = 4'h1;
  localparam logic [3:0]  F_DEPTH       = 4'h2;
  localparam logic [3:0]  F_DEPTH_STEN  = 4'h3;
  localparam logic [3:0]  F_RED         = 4'h4;
  localparam logic [3:0]  F_GREEN       = 4'h5;
  localparam logic [3:0]  F_BLUE        = 4'h6;
  localparam logic [3:0]  F_ALPHA       = 4'h7;
  localparam logic [3:0]  F_RGB         = 4'h8;
  localparam logic [3:0]  F_RGBA        = 4'h9;
  localparam logic [3:0]  F_GREY_SINGLE = 4'ha;
  localparam logic [3:0]  F_GREY_OPAC   = 4'hb;

  localparam logic [1:0]  T_UNORM       = 2'h0;
  localparam logic [1:0]  T_FLOAT       = 2'h1;
  localparam logic [1:0]  T_ONE_BIT_PER_ELEMENT_TYPE      = 2'h2;

  localparam logic [1:0]  SAT_OFF       = 2'h0;
  localparam logic [1:0]  SAT_ON        = 2'h1;
  localparam logic [1:0]  SAT_IF_FIXED  = 2'h2;
  localparam logic [1:0]  SAT_RESET     = SAT_IF_FIXED;

  typedef enum logic [4:0] {
    S_IDLE  = 5'b00001,
    S_SKIP  = 5'b00010,
    S_GROUP = 5'b00100,
    S_BITS  = 5'b01000,
    S_EMIT  = 5'b10000
  } prdc_state_e;
endpackage

/* logic/prdc_skid.sv */
// Purpose: Two-entry buffer in the fragment path
// Assumes: Source and sink share clk
// Notes:   Outputs come from registers; in_ready is a register too
`timescale 1ns/1ps
`default_nettype none
module prdc_skid #(
  parameter int W = 8
) (
  input  wire logic         clk,
  input  wire logic         arst_n,
  input  wire logic         in_valid,
  output logic              in_ready,
  input  wire logic [W-1:0] in_data,
  output logic              out_valid,
  input  wire logic         out_ready,
  output logic [W-1:0]      out_data
);
  logic         ov_reg, ov_next, sv_reg, sv_next;
  logic [W-1:0] od_reg, od_next, sd_reg, sd_next;

  always_comb begin
    ov_next = ov_reg;
    sv_next = sv_reg;
    od_next = od_reg;
    sd_next = sd_reg;
    if (out_ready || !ov_reg) begin
      if (sv_reg) begin
        od_next = sd_reg;
        ov_next = 1'b1;
        sv_next = 1'b0;
      end else begin
        od_next = in_data;
        ov_next = in_valid;
      end
    end else if (in_valid && !sv_reg) begin
      // Sink stalled: park the word instead of dropping it
      sd_next = in_data;
      sv_next = 1'b1;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      ov_reg <= 1'b0;
      sv_reg <= 1'b0;
      od_reg <= '0;
      sd_reg <= '0;
    end else begin
      ov_reg <= ov_next;
      sv_reg <= sv_next;
      od_reg <= od_next;
      sd_reg <= sd_next;
    end
  end

  assign in_ready  = !sv_reg;
  assign out_valid = ov_reg;
  assign out_data  = od_reg;
endmodule
`default_nettype wire

/* logic/prdc_core.sv */
// Purpose: Pixel groups of a rectangle draw in, zoomed fragments out
// Assumes: Request and raster inputs stay stable while draw_busy is high
// Notes:   Alignment must be 1, 2, 4 or 8; zero zoom yields no fragments
// Behaviour
// - Only unorm component groups are converted; indices and stencil stay raw
// - Single grey element is copied into R, G and B
// - Grey with opacity: first element to R, G, B, second to A
// - Missing A becomes one, integer or float as the components are
// - Missing R, G or B becomes zero
// - Colour index mode allows only index, stencil, depth, depth plus stencil
// - Formats with integer components are refused as illegal
// - Incomplete draw target raises the incomplete target error
// - One_bit_per_element_type byte gives eight bits, high first unless low bit first set
// - One_bit_per_element_type row pitch is alignment times ceil of row length over 8a
// - One_bit_per_element_type: skip rows times pitch, then per row skip columns, take width, step
// - Colour index integer part masked with index buffer bit mask
// - Float colour clamped to zero..one only while saturation is on
// - Three valued saturation setting, reset to saturate if fixed buffers
// - Depth clamped; fixed depth buffers also get window z conversion
// - Stencil indices masked with stencil buffer bit mask
// - Invalid raster position ignores the draw and updates no tables
// - Table update pulse does not wait for later fragment tests
// - Each group fills its zoomed rectangle with fragments, any zoom sign
// - Colour groups take raster depth; depth groups take raster colour
// - Fog, secondary colour and texture coordinates come from raster state
`timescale 1ns/1ps
`default_nettype none
module prdc_core import prdc_pkg::*; (
  input  wire logic               clk,
  input  wire logic               arst_n,
  input  wire logic               draw_start,
  input  wire logic [3:0]         req_format,
  input  wire logic [1:0]         req_type,
  input  wire logic               req_int_fmt,
  input  wire logic [15:0]        req_width,
  input  wire logic [15:0]        req_height,
  input  wire logic               ci_mode,
  input  wire logic               target_complete,
  input  wire logic               low_bit_first_order,
  input  wire logic [15:0]        rows_to_skip,
  input  wire logic [15:0]        columns_to_skip,
  input  wire logic [15:0]        row_length,
  input  wire logic [3:0]         alignment,
  input  wire logic signed [7:0]  zoom_x,
  input  wire logic signed [7:0]  zoom_y,
  input  wire logic               rp_valid,
  input  wire logic signed [15:0] rp_x,
  input  wire logic signed [15:0] rp_y,
  input  wire logic [15:0]        rp_depth,
  input  wire logic [63:0]        rp_colour,
  input  wire logic [15:0]        rp_index,
  input  wire logic [15:0]        rp_fog,
  input  wire logic [63:0]        rp_sec,
  input  wire logic [63:0]        rp_tex,
  input  wire logic [4:0]         index_bits,
  input  wire logic [3:0]         stencil_bits,
  input  wire logic               depth_fixed_buf,
  input  wire logic               all_fixed_bufs,
  input  wire logic               clamp_ctl_wr,
  input  wire logic [1:0]         clamp_ctl_val,
  input  wire logic               grp_valid,
  output logic                    grp_ready,
  input  wire logic [63:0]        grp_data,
  output logic                    frag_valid,
  input  wire logic               frag_ready,
  output logic [FRAG_W-1:0]       frag_data,
  output logic                    hist_update,
  output logic                    illegal_request_error,
  output logic                    incomplete_target_error,
  output logic                    draw_busy,
  output logic                    draw_done,
  output logic [1:0]              frag_colour_saturate_ctl
);
  function automatic logic [15:0] unorm(input logic [15:0] e);
    unorm = (e[7:0] == BYTE_FULL) ? FP_ONE : {4'h0, e[7:0], 4'h0};
  endfunction
  function automatic logic [15:0] sat(input logic [15:0] e);
    if (e[15]) sat = ELEM_ZERO;
    else if (e > FP_ONE) sat = FP_ONE;
    else sat = e;
  endfunction
  function automatic logic [15:0] mask(input logic [15:0] v, input logic [4:0] n);
    logic [16:0] m;
    m = (17'h00001 << n) - 17'h00001;
    mask = v & m[15:0];
  endfunction
  function automatic logic [15:0] pitch(input logic [15:0] l, input logic [3:0] a);
    logic [15:0] c;
    logic [15:0] am;
    c = {3'h0, l[15:3]} + {15'h0000, |l[2:0]};
    am = {12'h000, a} - 16'h0001;
    pitch = (c + am) & ~am;
  endfunction
  function automatic logic [15:0] origin(input logic signed [15:0] rp,
                                         input logic signed [7:0] z,
                                         input logic [15:0] n);
    logic signed [31:0] a;
    logic signed [31:0] b;
    a = 32'(z) * $signed({16'h0000, n});
    b = a + 32'(z);
    origin = 16'(32'(rp) + ((z < 0) ? b : a));
  endfunction
  function automatic logic [7:0] mag(input logic signed [7:0] z);
    mag = z[7] ? 8'(-z) : z;
  endfunction

  prdc_state_e        state_reg, state_next;
  logic [15:0]        n_reg, n_next, m_reg, m_next, w_reg, w_next, h_reg, h_next;
  logic [7:0]         dx_reg, dx_next, dy_reg, dy_next;
  logic [15:0]        x0_reg, x0_next, y0_reg, y0_next;
  logic [63:0]        col_reg, col_next;
  logic [15:0]        dep_reg, dep_next, idx_reg, idx_next;
  logic [7:0]         sten_reg, sten_next, byte_reg, byte_next;
  logic [3:0]         fmt_reg, fmt_next;
  logic [1:0]         ty_reg, ty_next, sat_reg, sat_next;
  logic               int_reg, int_next, lsb_reg, lsb_next, emit_reg, emit_next;
  logic [15:0]        k_reg, k_next, cs_reg, cs_next, bidx_reg, bidx_next;
  logic [31:0]        skip_reg, skip_next;
  logic [2:0]         bit_reg, bit_next;
  logic               rdy_reg, rdy_next, hist_reg, hist_next, done_reg, done_next;
  logic               eill_reg, eill_next, einc_reg, einc_next, busy_reg, busy_next;
  logic               take, buf_ready, sat_on, bad_ci, last_grp, bitval, in_win;
  logic [15:0]        e0, e1, e2, e3, d, one, r, g, b, a;
  logic [31:0]        pos;
  logic [15:0]        col_n;
  logic [7:0]         ax, ay;

  always_comb begin
    sat_next = clamp_ctl_wr ? clamp_ctl_val : sat_reg;
    // Saturation decision follows the current buffer mix
    sat_on = (sat_reg == SAT_ON) || ((sat_reg == SAT_IF_FIXED) && all_fixed_bufs);
    take   = grp_valid && rdy_reg;
    {ax, ay} = {mag(zoom_x), mag(zoom_y)};
    one    = int_reg ? INT_ONE : FP_ONE;
    // Conversion skips indices and the stencil half of depth plus stencil
    e0 = (ty_reg == T_UNORM && fmt_reg >= F_DEPTH) ? unorm(grp_data[63:48]) : grp_data[63:48];
    e1 = (ty_reg == T_UNORM && fmt_reg >= F_RED) ? unorm(grp_data[47:32]) : grp_data[47:32];
    e2 = (ty_reg == T_UNORM) ? unorm(grp_data[31:16]) : grp_data[31:16];
    e3 = (ty_reg == T_UNORM) ? unorm(grp_data[15:0]) : grp_data[15:0];
    {r, g, b} = {3{ELEM_ZERO}};
    a = one;
    unique case (fmt_reg)
      F_RED:         r = e0;
      F_GREEN:       g = e0;
      F_BLUE:        b = e0;
      F_ALPHA:       a = e0;
      F_RGB:         {r, g, b} = {e0, e1, e2};
      F_RGBA:        {r, g, b, a} = {e0, e1, e2, e3};
      F_GREY_SINGLE: {r, g, b} = {e0, e0, e0};
      F_GREY_OPAC:   {r, g, b, a} = {e0, e0, e0, e1};
      default: ;
    endcase
    if (sat_on && !int_reg) begin
      {r, g, b, a} = {sat(r), sat(g), sat(b), sat(a)};
    end
    d = sat(e0);
    if (depth_fixed_buf) begin
      d = (d == FP_ONE) ? WINZ_MAX : {d[11:0], 4'h0};
    end
    bad_ci   = ci_mode && (req_format > F_DEPTH_STEN);
    last_grp = (n_reg == w_reg - 16'h0001) && (m_reg == h_reg - 16'h0001);
    pos      = ({bidx_reg, 16'h0000} >> 13) + {29'h0, bit_reg};
    col_n    = 16'(pos - {16'h0000, cs_reg});
    in_win   = (pos >= {16'h0000, cs_reg}) && (pos < {16'h0000, cs_reg} + {16'h0000, w_reg});
    bitval   = lsb_reg ? byte_reg[bit_reg] : byte_reg[LAST_BIT - bit_reg];
  end

  always_comb begin
    state_next = state_reg;
    {n_next, m_next, w_next, h_next} = {n_reg, m_reg, w_reg, h_reg};
    {dx_next, dy_next, x0_next, y0_next} = {dx_reg, dy_reg, x0_reg, y0_reg};
    {col_next, dep_next, idx_next, sten_next} = {col_reg, dep_reg, idx_reg, sten_reg};
    {byte_next, fmt_next, ty_next, int_next} = {byte_reg, fmt_reg, ty_reg, int_reg};
    {lsb_next, emit_next, k_next, cs_next} = {lsb_reg, emit_reg, k_reg, cs_reg};
    {bidx_next, skip_next, bit_next} = {bidx_reg, skip_reg, bit_reg};
    {hist_next, done_next, eill_next, einc_next} = 4'h0;
    unique case (state_reg)
      S_IDLE: begin
        if (draw_start) begin
          eill_next = bad_ci || req_int_fmt;
          einc_next = !target_complete;
          // Invalid raster position: quietly drop the whole draw
          if (bad_ci || req_int_fmt || !target_complete || !rp_valid ||
              req_width == 16'h0000 || req_height == 16'h0000) begin
            done_next = 1'b1;
          end else begin
            {fmt_next, ty_next, int_next} = {req_format, req_type, req_int_fmt};
            {lsb_next, w_next, h_next} = {low_bit_first_order, req_width, req_height};
            {cs_next, n_next, m_next, bidx_next} = {columns_to_skip, 48'h0};
            k_next = pitch((row_length != 16'h0000) ? row_length : req_width, alignment);
            skip_next = rows_to_skip * k_next;
            state_next = (req_type == T_ONE_BIT_PER_ELEMENT_TYPE && skip_next != 32'h0) ? S_SKIP : S_GROUP;
          end
        end
      end
      S_SKIP: begin
        if (take) begin
          skip_next = skip_reg - 32'h1;
          if (skip_reg == 32'h1) state_next = S_GROUP;
        end
      end
      S_GROUP: begin
        if (take && ty_reg == T_ONE_BIT_PER_ELEMENT_TYPE) begin
          {byte_next, bit_next, emit_next} = {grp_data[7:0], 4'h0};
          state_next = S_BITS;
        end else if (take) begin
          hist_next = 1'b1;
          col_next = {r, g, b, a};
          dep_next = rp_depth;
          idx_next = mask((ty_reg == T_FLOAT) ? e0 >> FP_INT_LSB : e0, index_bits);
          sten_next = 8'(mask(e0, {1'b0, stencil_bits}));
          if (fmt_reg == F_DEPTH || fmt_reg == F_DEPTH_STEN) begin
            {col_next, idx_next} = {rp_colour, rp_index};
            dep_next = d;
            sten_next = 8'(mask(e1, {1'b0, stencil_bits}));
          end
          x0_next = origin(rp_x, zoom_x, n_reg);
          y0_next = origin(rp_y, zoom_y, m_reg);
          if (ax != 8'h00 && ay != 8'h00) state_next = S_EMIT;
          else if (last_grp) state_next = S_IDLE;
          if (n_reg == w_reg - 16'h0001) begin
            n_next = 16'h0000;
            m_next = m_reg + 16'h0001;
          end else begin
            n_next = n_reg + 16'h0001;
          end
          // Position counters run ahead; the origin is already latched
          if (last_grp && (ax == 8'h00 || ay == 8'h00)) done_next = 1'b1;
        end
      end
      S_BITS: begin
        if (in_win && !emit_reg) begin
          emit_next = 1'b1;
          hist_next = 1'b1;
          {col_next, dep_next} = {rp_colour, rp_depth};
          idx_next = mask({15'h0000, bitval}, index_bits);
          sten_next = 8'h00;
          x0_next = origin(rp_x, zoom_x, col_n);
          y0_next = origin(rp_y, zoom_y, m_reg);
          if (ax != 8'h00 && ay != 8'h00) state_next = S_EMIT;
        end else begin
          emit_next = 1'b0;
          bit_next = bit_reg + 3'h1;
          if (bit_reg == LAST_BIT) begin
            state_next = S_GROUP;
            bidx_next = bidx_reg + 16'h0001;
            // Whole pitch is consumed even past the taken width
            if (bidx_reg == k_reg - 16'h0001) begin
              {bidx_next, m_next} = {16'h0000, m_reg + 16'h0001};
              if (m_reg == h_reg - 16'h0001) begin
                state_next = S_IDLE;
                done_next = 1'b1;
              end
            end
          end
        end
      end
      S_EMIT: begin
        if (buf_ready) begin
          dx_next = dx_reg + 8'h01;
          if (dx_reg == ax - 8'h01) begin
            {dx_next, dy_next} = {8'h00, dy_reg + 8'h01};
            if (dy_reg == ay - 8'h01) begin
              dy_next = 8'h00;
              if (ty_reg == T_ONE_BIT_PER_ELEMENT_TYPE) begin
                state_next = S_BITS;
              end else if (n_reg == 16'h0000 && m_reg == h_reg) begin
                state_next = S_IDLE;
                done_next = 1'b1;
              end else begin
                state_next = S_GROUP;
              end
            end
          end
        end
      end
      default: state_next = S_IDLE;
    endcase
    rdy_next = (state_next == S_GROUP) || (state_next == S_SKIP);
    busy_next = (state_next != S_IDLE);
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      state_reg <= S_IDLE;
      sat_reg <= SAT_RESET;
      {n_reg, m_reg, w_reg, h_reg, x0_reg, y0_reg} <= '0;
      {dx_reg, dy_reg, col_reg, dep_reg, idx_reg, sten_reg, byte_reg} <= '0;
      {fmt_reg, ty_reg, int_reg, lsb_reg, emit_reg, k_reg, cs_reg} <= '0;
      {bidx_reg, skip_reg, bit_reg, rdy_reg, hist_reg, done_reg} <= '0;
      {eill_reg, einc_reg, busy_reg} <= '0;
    end else begin
      state_reg <= state_next;
      sat_reg <= sat_next;
      {n_reg, m_reg, w_reg, h_reg, x0_reg, y0_reg} <=
        {n_next, m_next, w_next, h_next, x0_next, y0_next};
      {dx_reg, dy_reg, col_reg, dep_reg, idx_reg, sten_reg, byte_reg} <=
        {dx_next, dy_next, col_next, dep_next, idx_next, sten_next, byte_next};
      {fmt_reg, ty_reg, int_reg, lsb_reg, emit_reg, k_reg, cs_reg} <=
        {fmt_next, ty_next, int_next, lsb_next, emit_next, k_next, cs_next};
      {bidx_reg, skip_reg, bit_reg, rdy_reg, hist_reg, done_reg} <=
        {bidx_next, skip_next, bit_next, rdy_next, hist_next, done_next};
      {eill_reg, einc_reg, busy_reg} <= {eill_next, einc_next, busy_next};
    end
  end

  // Buffer keeps emission running one word past a receiver stall
  prdc_skid #(
    .W(FRAG_W)
  ) u_buf (
    .clk      (clk),
    .arst_n   (arst_n),
    .in_valid (state_reg == S_EMIT),
    .in_ready (buf_ready),
    .in_data  ({x0_reg + {8'h00, dx_reg}, y0_reg + {8'h00, dy_reg}, col_reg, dep_reg,
                idx_reg, sten_reg, rp_fog, rp_sec, rp_tex}),
    .out_valid(frag_valid),
    .out_ready(frag_ready),
    .out_data (frag_data)
  );

  assign grp_ready = rdy_reg;
  assign hist_update = hist_reg;
  assign illegal_request_error = eill_reg;
  assign incomplete_target_error = einc_reg;
  assign draw_busy = busy_reg;
  assign draw_done = done_reg;
  assign frag_colour_saturate_ctl = sat_reg;
endmodule
`default_nettype wire

/* verif/prdc_core_properties.sv */
// Purpose: Port-level checks for the pixel rectangle draw converter
// Assumes: Bound to prdc_core; one clock domain
// Notes:   Error pulses may land one or two cycles after the start
`timescale 1ns/1ps
`default_nettype none
module prdc_core_chk import prdc_pkg::*; (
  input wire logic               clk,
  input wire logic               arst_n,
  input wire logic               draw_start,
  input wire logic [3:0]         req_format,
  input wire logic [1:0]         req_type,
  input wire logic               req_int_fmt,
  input wire logic               ci_mode,
  input wire logic               target_complete,
  input wire logic               rp_valid,
  input wire logic signed [7:0]  zoom_x,
  input wire logic signed [7:0]  zoom_y,
  input wire logic [15:0]        rp_fog,
  input wire logic [63:0]        rp_sec,
  input wire logic [63:0]        rp_tex,
  input wire logic               clamp_ctl_wr,
  input wire logic [1:0]         clamp_ctl_val,
  input wire logic               grp_valid,
  input wire logic               grp_ready,
  input wire logic               frag_valid,
  input wire logic               frag_ready,
  input wire logic [FRAG_W-1:0]  frag_data,
  input wire logic               hist_update,
  input wire logic               illegal_request_error,
  input wire logic               incomplete_target_error,
  input wire logic               draw_busy,
  input wire logic [1:0]         frag_colour_saturate_ctl
);
  default clocking @(posedge clk); endclocking
  default disable iff (!arst_n);
  logic start_ok;
  assign start_ok = draw_start && !draw_busy;
  sat_init_a: assert property (
    $rose(arst_n) |-> frag_colour_saturate_ctl == SAT_IF_FIXED) else $error("bad reset setting");
  sat_write_a: assert property (
    clamp_ctl_wr |=> frag_colour_saturate_ctl == $past(clamp_ctl_val)) else $error("setting lost");
  ci_mode_a: assert property (
    start_ok && ci_mode && req_format > F_DEPTH_STEN |-> ##[1:2] illegal_request_error)
    else $error("index mode format accepted");
  int_fmt_a: assert property (
    start_ok && req_int_fmt |-> ##[1:2] illegal_request_error) else $error("integer format taken");
  target_check_a: assert property (
    start_ok && !target_complete |-> ##[1:2] incomplete_target_error) else $error("no target error");
  raster_off_a: assert property (
    start_ok && !rp_valid |=> !hist_update [*4]) else $error("tables updated on invalid raster");
  take_hist_a: assert property (
    req_type != T_ONE_BIT_PER_ELEMENT_TYPE && grp_valid && grp_ready |-> ##[1:2] hist_update)
    else $error("no table update for group");
  take_drop_a: assert property (
    req_type != T_ONE_BIT_PER_ELEMENT_TYPE && zoom_x != 0 && zoom_y != 0 && grp_valid && grp_ready |=> !grp_ready)
    else $error("ready held after take");
  frag_hold_a: assert property (
    frag_valid && !frag_ready |=> frag_valid && $stable(frag_data)) else $error("fragment dropped");
  raster_attr_a: assert property (
    frag_valid |-> frag_data[143:0] == {rp_fog, rp_sec, rp_tex}) else $error("bad raster attributes");
endmodule
bind prdc_core prdc_core_chk i_chk (.*);
`default_nettype wire

/* verif/prdc_frag_sink.sv */
// Purpose: Fragment pipeline stand-in that stalls at random
// Assumes: Shares clk with the converter
// Notes:   Ready is registered, so stalls begin and end on edges
`timescale 1ns/1ps
`default_nettype none
module prdc_frag_sink (
  input  wire logic clk,
  input  wire logic arst_n,
  output logic      frag_ready
);
  // Half the cycles stall so the two-entry buffer fills
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      frag_ready <= 1'b0;
    end else begin
      frag_ready <= ($urandom_range(0, 1) != 0);
    end
  end
endmodule
`default_nettype wire

/* verif/tb.sv */
// Purpose: Self-checking bench for prdc_core
// Assumes: Float groups in Q4.12; raster state other than rp_valid held for the whole run
// Notes:   One_bit_per_element_type unpacking is not exercised here
`timescale 1ns/1ps
`default_nettype none
module tb;
  import prdc_pkg::*;
  logic               clk = '0, arst_n = '0, draw_start = '0, req_int_fmt = '0, ci_mode = '0;
  logic               target_complete = '1, rp_valid = '1, clamp_ctl_wr = '0, grp_valid = '0;
  logic               low_bit_first_order = '0, depth_fixed_buf = '0, all_fixed_bufs = '0;
  logic [3:0]         req_format = F_RGBA, alignment = 4'h1, stencil_bits = '0;
  logic [1:0]         req_type = T_FLOAT, clamp_ctl_val = SAT_OFF;
  logic [15:0]        req_width = 16'h1, req_height = 16'h1, row_length = '0;
  logic [15:0]        rows_to_skip = '0, columns_to_skip = '0, rp_depth = '0, rp_index = '0;
  logic [15:0]        rp_fog = '0, e0, e1;
  logic [63:0]        rp_colour = '0, rp_sec = '0, rp_tex = '0, grp_data = '0, expc;
  logic signed [7:0]  zoom_x = 8'sh1, zoom_y = 8'sh1;
  logic signed [15:0] rp_x = 16'sh10, rp_y = 16'sh20;
  logic [4:0]         index_bits = '0;
  logic               grp_ready, frag_valid, frag_ready, hist_update, draw_busy, draw_done;
  logic               illegal_request_error, incomplete_target_error;
  logic               ill_seen, inc_seen, hu_seen, done_seen;
  logic [1:0]         frag_colour_saturate_ctl;
  logic [FRAG_W-1:0]  frag_data;
  logic [FRAG_W-1:0]  fq[$];
  int                 fails = 0, check_count = 0, i, ax, ay, x0, y0;
  int                 zxs[6] = '{2, -1, 3, 1, 0, 1};
  int                 zys[6] = '{1, 2, -2, -3, 2, 1};

  prdc_core i_dut (.*);
  prdc_frag_sink i_sink (.*);

  always #2.5 clk = ~clk;
  always @(posedge clk) begin
    if (frag_valid && frag_ready) fq.push_back(frag_data);
  end

  task automatic chk_bit(string nm, logic e, logic g);
    check_count++;
    if (g !== e) begin
      fails++;
      $display("mismatch %s exp %0h got %0h", nm, e, g);
    end
  endtask
  task automatic chk_word(string nm, logic [63:0] e, logic [63:0] g);
    check_count++;
    if (g !== e) begin
      fails++;
      $display("mismatch %s exp %0h got %0h", nm, e, g);
    end
  endtask
  task automatic end_sim();
    $display("checks %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  // Pulses are gathered over a few cycles, their latency is the design's choice
  task automatic start_draw();
    {ill_seen, inc_seen, hu_seen, done_seen} = '0;
    draw_start <= 1'b1;
    @(posedge clk);
    draw_start <= 1'b0;
    repeat (3) begin
      @(posedge clk);
      ill_seen |= illegal_request_error;
      inc_seen |= incomplete_target_error;
      hu_seen |= hist_update;
      done_seen |= draw_done;
    end
  endtask
  // Saturation clamps only values above one; inputs stay non-negative
  function automatic logic [63:0] exp_colour(logic [15:0] a, logic [15:0] b, logic op, logic s);
    logic [15:0] ca, cb;
    ca = (s && a > FP_ONE) ? FP_ONE : a;
    cb = op ? ((s && b > FP_ONE) ? FP_ONE : b) : FP_ONE;
    return {ca, ca, ca, cb};
  endfunction
  // Depth is always clamped; a fixed buffer maps one to all ones
  function automatic logic [15:0] exp_depth(logic [15:0] v);
    logic [15:0] cv;
    cv = (v > FP_ONE) ? FP_ONE : v;
    return depth_fixed_buf ? ((cv == FP_ONE) ? WINZ_MAX : {cv[11:0], 4'h0}) : cv;
  endfunction

  initial begin
    repeat (5000) @(posedge clk);
    fails++;
    $display("mismatch watchdog exp finish got hang");
    end_sim();
  end

  initial begin
    void'($urandom(32'he6cd309b));
    {rp_depth, rp_index, rp_fog} <= {$urandom, $urandom};
    {rp_colour, rp_sec, rp_tex} <= {$urandom, $urandom, $urandom, $urandom, $urandom, $urandom};
    {low_bit_first_order, depth_fixed_buf, all_fixed_bufs, index_bits} <= $urandom;
    {stencil_bits, rows_to_skip, columns_to_skip} <= $urandom;
    alignment <= 4'h1 << $urandom_range(0, 3);
    repeat (20) @(posedge clk);
    arst_n <= 1'b1;
    repeat (2) @(posedge clk);
    chk_word("sat_ctl", SAT_IF_FIXED, frag_colour_saturate_ctl);
    for (int c = 0; c < 4; c++) begin
      ci_mode <= (c == 0);
      req_int_fmt <= (c == 1);
      target_complete <= (c != 2);
      rp_valid <= (c != 3);
      start_draw();
      chk_bit("illegal", c < 2, ill_seen);
      chk_bit("incomplete", c == 2, inc_seen);
      chk_bit("hist_update", 1'b0, hu_seen);
      chk_bit("draw_done", 1'b1, done_seen);
    end
    rp_valid <= 1'b1;
    for (int c = 0; c < 6; c++) begin
      e0 = 16'($urandom_range(0, 16'h1fff));
      e1 = 16'($urandom_range(0, 16'h1fff));
      clamp_ctl_wr <= 1'b1;
      clamp_ctl_val <= c[0] ? SAT_ON : SAT_OFF;
      @(posedge clk);
      clamp_ctl_wr <= 1'b0;
      req_format <= (c == 5) ? F_DEPTH : c[1] ? F_GREY_OPAC : F_GREY_SINGLE;
      zoom_x <= 8'(zxs[c]);
      zoom_y <= 8'(zys[c]);
      @(posedge clk);
      chk_word("sat_ctl", c[0] ? SAT_ON : SAT_OFF, frag_colour_saturate_ctl);
      fq.delete();
      start_draw();
      grp_valid <= 1'b1;
      grp_data <= {e0, e1, 32'h0};
      i = 0;
      do begin
        @(posedge clk);
        i++;
      end while (!grp_ready && i < 50);
      grp_valid <= 1'b0;
      chk_bit("grp_taken", 1'b1, grp_ready);
      chk_bit("draw_busy", 1'b1, draw_busy);
      i = 0;
      while (!draw_done && i < 60) begin
        @(posedge clk);
        i++;
      end
      chk_bit("draw_done", 1'b1, draw_done);
      repeat (40) @(posedge clk);
      ax = zxs[c] < 0 ? -zxs[c] : zxs[c];
      ay = zys[c] < 0 ? -zys[c] : zys[c];
      x0 = rp_x + (zxs[c] < 0 ? zxs[c] : 0);
      y0 = rp_y + (zys[c] < 0 ? zys[c] : 0);
      expc = (c == 5) ? rp_colour : exp_colour(e0, e1, c[1], c[0]);
      chk_word("frag_count", 64'(ax * ay), 64'(fq.size()));
      foreach (fq[k]) begin
        chk_word("frag_x", 16'(x0 + k % ax), fq[k][279:264]);
        chk_word("frag_y", 16'(y0 + k / ax), fq[k][263:248]);
        chk_word("frag_colour", expc, fq[k][247:184]);
        chk_word("frag_depth", (c == 5) ? exp_depth(e0) : rp_depth, fq[k][183:168]);
      end
    end
    end_sim();
  end
endmodule
`default_nettype wire
